// ===== rtl/chip_addr_map.svh
// offsets, field positions, reset values and timing of the address and id registers
`ifndef CHIP_ADDR_MAP_SVH
`define CHIP_ADDR_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define INDIVIDUAL_CHIP_ADDRESS_OFS 8'h1B
`define PART_AND_REVISION_ID_OFS 8'h1C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define OWN_ADDRESS_MSB 7
`define OWN_ADDRESS_LSB 1
`define CHAIN_ENABLE_BIT 0
`define PART_CODE_MSB 7
`define PART_CODE_LSB 4
`define REVISION_CODE_MSB 3
`define REVISION_CODE_LSB 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SPI_OWN_ADDRESS_RESET 7'h40
`define CHAIN_ENABLE_RESET 1'b0
`define UNMAPPED_READ_VALUE 8'h00

// ------------------------------------------------------------
// timing counts, in core clock cycles
// ------------------------------------------------------------
`define READ_LATENCY_CYCLES 1
`define STRAP_SYNC_STAGES 2

`endif

// ===== rtl/chip_addr_pkg.sv
// types shared by the address and id register modules
package chip_addr_pkg;

    // one register byte
    typedef logic [7:0] reg_byte_t;

    // a seven bit bus address
    typedef logic [6:0] own_address_t;

    // four bit code fields of the id register
    typedef logic [3:0] code_nibble_t;

    // which register an access selects
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ADDRESS,
        SEL_ID
    } reg_sel_t;

endpackage : chip_addr_pkg

// ===== rtl/id_bus_if.sv
// carrier between the register bank and its fixed id store
`timescale 1ns/1ps
`default_nettype none

interface id_bus_if;
    import chip_addr_pkg::*;

    // attempted write to the id register, seen by the store
    logic write_attempt;
    // contents of the id register
    reg_byte_t id_data;

    modport provider (
        input write_attempt,
        output id_data
    );

    modport user (
        output write_attempt,
        input id_data
    );
endinterface : id_bus_if

`default_nettype wire

// ===== rtl/part_id_store.sv
// fixed part and revision code store behind the id register
`timescale 1ns/1ps
`default_nettype none

`include "chip_addr_map.svh"

module part_id_store #(
    // arbitrary neutral part code
    parameter logic [3:0] PART_CODE = 4'h5,
    // arbitrary neutral revision code
    parameter logic [3:0] REVISION_CODE = 4'h1
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    // link to the register bank
    id_bus_if.provider id_bus
);
    import chip_addr_pkg::*;

    // ------------------------------------------------------------
    // id contents
    // ------------------------------------------------------------

    // held in a flop so the read path starts from a register; reloaded
    // on every cycle with clk_en_in high, so no write or upset can stick
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            id_bus.id_data <= {PART_CODE, REVISION_CODE};
        end else if (clk_en_in) begin
            id_bus.id_data[`PART_CODE_MSB:`PART_CODE_LSB] <= PART_CODE;
            id_bus.id_data[`REVISION_CODE_MSB:`REVISION_CODE_LSB] <= REVISION_CODE;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    property p_part_code_fixed;
        @(posedge core_clk_in) disable iff (!rstn_in)
        id_bus.write_attempt |=> id_bus.id_data[7:4] == PART_CODE;
    endproperty
    a_part_code_fixed: assert property (p_part_code_fixed) else $error("part code changed");

    property p_revision_code_fixed;
        @(posedge core_clk_in) disable iff (!rstn_in)
        $past(rstn_in) |-> id_bus.id_data[3:0] == REVISION_CODE;
    endproperty
    a_revision_code_fixed: assert property (p_revision_code_fixed) else $error("revision code wrong");

    property p_write_leaves_id;
        @(posedge core_clk_in) disable iff (!rstn_in)
        id_bus.write_attempt && $past(rstn_in) |=> $stable(id_bus.id_data);
    endproperty
    a_write_leaves_id: assert property (p_write_leaves_id) else $error("id altered by write");

endmodule : part_id_store

`default_nettype wire

// ===== rtl/chip_address_and_id_regs.sv
// individual chip address register and read-only id register of the serial control port
`timescale 1ns/1ps
`default_nettype none

`include "chip_addr_map.svh"

// Summary of operation
// - seven bit own address sits in bits 7:1, writable whenever reset is released and clk_en_in is high.
// - in spi mode the own address resets to binary 1000000.
// - bit 0 of the address register drives the chain enable pin level.
// - chain enable bit resets to zero, so the pin starts low.
// - id register is read only and returns fixed contents on each read.
// - id bits 7:4 hold a fixed part code, unchangeable by write or reset.
// - id bits 3:0 hold the silicon revision code.
module chip_address_and_id_regs (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    // mode and address straps from pins
    input wire logic spi_mode_in,
    input wire logic [6:0] addr_strap_in,
    // register access from the serial port decoder
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire chip_addr_pkg::reg_byte_t reg_addr_in,
    input wire chip_addr_pkg::reg_byte_t reg_wdata_in,
    output chip_addr_pkg::reg_byte_t reg_rdata_out,
    output logic reg_rvalid_out,
    // address in use and next device enable pin
    output chip_addr_pkg::own_address_t own_address_out,
    output logic chain_enable_output_out
);
    import chip_addr_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------

    localparam int SYNC_STAGES = `STRAP_SYNC_STAGES;

    logic [SYNC_STAGES-1:0] spi_mode_sync;
    logic [SYNC_STAGES-1:0] strap_sync [7];
    logic spi_mode_s;
    own_address_t strap_s;
    own_address_t own_address;
    logic chain_enable;
    reg_sel_t sel;
    reg_byte_t next_rdata;
    logic wr_address;
    logic wr_id;

    id_bus_if id_bus ();

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------

    // straps come from pins; two stages before anything reads them.
    // not reset, so they keep tracking the pins while reset is held
    always_ff @(posedge core_clk_in) begin
        if (clk_en_in) begin
            spi_mode_sync <= {spi_mode_sync[SYNC_STAGES-2:0], spi_mode_in};
        end
    end

    generate
        for (genvar b = 0; b < 7; b++) begin : g_strap_sync
            // one two-stage chain per strap bit
            always_ff @(posedge core_clk_in) begin
                if (clk_en_in) begin
                    strap_sync[b] <= {strap_sync[b][SYNC_STAGES-2:0], addr_strap_in[b]};
                end
            end
            assign strap_s[b] = strap_sync[b][SYNC_STAGES-1];
        end
    endgenerate

    assign spi_mode_s = spi_mode_sync[SYNC_STAGES-1];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // one select for both the write and the read path
    always_comb begin
        sel = SEL_NONE;
        case (reg_addr_in)
            `INDIVIDUAL_CHIP_ADDRESS_OFS: begin
                sel = SEL_ADDRESS;
            end
            `PART_AND_REVISION_ID_OFS: begin
                sel = SEL_ID;
            end
            default: begin
                sel = SEL_NONE;
            end
        endcase
    end

    assign wr_address = reg_wr_in && (sel == SEL_ADDRESS);
    assign wr_id = reg_wr_in && (sel == SEL_ID);

    // the store sees the attempt but has no path to take the data
    assign id_bus.write_attempt = wr_id && clk_en_in;

    // ------------------------------------------------------------
    // individual chip address register
    // ------------------------------------------------------------

    // reset value follows the port mode; the strap is resampled on every
    // reset cycle, so reset must outlast the synchroniser depth
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            if (spi_mode_s) begin
                own_address <= `SPI_OWN_ADDRESS_RESET;
            end else begin
                own_address <= strap_s;
            end
        end else if (clk_en_in && wr_address) begin
            own_address <= reg_wdata_in[`OWN_ADDRESS_MSB:`OWN_ADDRESS_LSB];
        end
    end

    // next device enable bit, low out of reset
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            chain_enable <= `CHAIN_ENABLE_RESET;
        end else if (clk_en_in && wr_address) begin
            chain_enable <= reg_wdata_in[`CHAIN_ENABLE_BIT];
        end
    end

    assign own_address_out = own_address;
    // straight from the flop, no glitch on the chain pin
    assign chain_enable_output_out = chain_enable;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // unmapped offsets read zero rather than stale data
    always_comb begin
        next_rdata = `UNMAPPED_READ_VALUE;
        case (sel)
            SEL_ADDRESS: begin
                next_rdata = {own_address, chain_enable};
            end
            SEL_ID: begin
                next_rdata = id_bus.id_data;
            end
            default: begin
                next_rdata = `UNMAPPED_READ_VALUE;
            end
        endcase
    end

    // read data registered; it holds until the next read
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= `UNMAPPED_READ_VALUE;
        end else if (clk_en_in && reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // one-cycle valid set by the same edge that takes the read
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            reg_rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            reg_rvalid_out <= reg_rd_in;
        end
    end

    // ------------------------------------------------------------
    // fixed id store
    // ------------------------------------------------------------

    part_id_store u_part_id_store (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .clk_en_in(clk_en_in),
        .id_bus(id_bus.provider)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    sequence s_addr_write;
        clk_en_in && reg_wr_in && reg_addr_in == `INDIVIDUAL_CHIP_ADDRESS_OFS;
    endsequence

    sequence s_id_write;
        clk_en_in && reg_wr_in && reg_addr_in == `PART_AND_REVISION_ID_OFS;
    endsequence

    sequence s_id_read;
        clk_en_in && reg_rd_in && !reg_wr_in && reg_addr_in == `PART_AND_REVISION_ID_OFS;
    endsequence

    property p_address_written;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_addr_write |=> own_address_out == $past(reg_wdata_in[7:1]);
    endproperty
    a_address_written: assert property (p_address_written) else $error("own address not updated");

    property p_spi_reset_address;
        @(posedge core_clk_in) disable iff (!rstn_in)
        $past(!rstn_in) && $past(spi_mode_s) |-> own_address_out == 7'h40;
    endproperty
    a_spi_reset_address: assert property (p_spi_reset_address) else $error("spi reset address wrong");

    property p_chain_follows_bit;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_addr_write |=> chain_enable_output_out == $past(reg_wdata_in[0]);
    endproperty
    a_chain_follows_bit: assert property (p_chain_follows_bit) else $error("chain pin does not follow bit");

    property p_chain_low_after_reset;
        @(posedge core_clk_in) disable iff (!rstn_in)
        $past(!rstn_in) |-> !chain_enable_output_out;
    endproperty
    a_chain_low_after_reset: assert property (p_chain_low_after_reset) else $error("chain pin high after reset");

    property p_id_read_returns;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_id_read |=> reg_rvalid_out && reg_rdata_out == id_bus.id_data;
    endproperty
    a_id_read_returns: assert property (p_id_read_returns) else $error("id read data wrong");

    // write, one idle cycle, then read; the read must return the contents
    // sampled before the write was taken
    property p_id_write_ignored;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_id_write ##2 s_id_read |=> reg_rdata_out == $past(id_bus.id_data, 3);
    endproperty
    a_id_write_ignored: assert property (p_id_write_ignored) else $error("id write took effect");

    property p_id_write_keeps_address;
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_id_write |=> $stable(own_address_out) && $stable(chain_enable_output_out);
    endproperty
    a_id_write_keeps_address: assert property (p_id_write_keeps_address) else $error("id write hit address");

    property p_freeze;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !clk_en_in |=> $stable(own_address_out) && $stable(reg_rvalid_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule : chip_address_and_id_regs

`default_nettype wire

// ===== dv/reg_host_model.sv
// system controller model issuing single byte register accesses
`timescale 1ns/1ps
`default_nettype none

module reg_host_model (
    // clock
    input wire logic clk_in,
    // answer from the register bank
    input wire chip_addr_pkg::reg_byte_t rdata_in,
    input wire logic rvalid_in,
    // request to the register bank
    output logic wr_out,
    output logic rd_out,
    output chip_addr_pkg::reg_byte_t addr_out,
    output chip_addr_pkg::reg_byte_t wdata_out
);
    import chip_addr_pkg::*;

    // idle request lines at time zero
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end

    // one write strobe, taken at the next edge; released lines show the inverse
    task automatic write_reg(input reg_byte_t addr, input reg_byte_t data);
        @(posedge clk_in);
        #1;
        wr_out = 1'b1;
        addr_out = addr;
        wdata_out = data;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : write_reg

    // one read strobe; answer is sampled 1 ns after the taking edge
    task automatic read_reg(input reg_byte_t addr, output reg_byte_t data, output logic valid);
        @(posedge clk_in);
        #1;
        rd_out = 1'b1;
        addr_out = addr;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        valid = rvalid_in;
        data = rdata_in;
    endtask : read_reg
endmodule : reg_host_model

`default_nettype wire

// ===== dv/chip_address_and_id_regs_tb.sv
// self-checking bench for the address and id register bank
`timescale 1ns/1ps
`default_nettype none

module chip_address_and_id_regs_tb;
    import chip_addr_pkg::*;

    // expected id byte: arbitrary neutral part and revision codes of the store
    localparam reg_byte_t ID_EXP = 8'h51;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic spi_mode = 1'b1;
    logic [6:0] strap = 7'h2A;
    logic wr;
    logic rd;
    reg_byte_t addr;
    reg_byte_t wdata;
    reg_byte_t rdata;
    logic rvalid;
    own_address_t own;
    logic chain;
    reg_byte_t rd_val;
    logic rd_ok;
    reg_byte_t vals [4] = '{8'h83, 8'hFE, 8'h01, 8'h00};
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // clock, design and host
    // ------------------------------------------------------------
    always #50 core_clk = ~core_clk;

    chip_address_and_id_regs dut_u (
        .core_clk_in(core_clk), .rstn_in(rstn), .clk_en_in(clk_en),
        .spi_mode_in(spi_mode), .addr_strap_in(strap),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .own_address_out(own), .chain_enable_output_out(chain)
    );

    reg_host_model host_u (
        .clk_in(core_clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // straps move during reset so the resampling is exercised
    task automatic do_reset(input logic spi, input logic [6:0] pins);
        @(posedge core_clk);
        #1;
        rstn = 1'b0;
        spi_mode = spi;
        strap = pins;
        repeat (8) @(posedge core_clk);
        #1;
        rstn = 1'b1;
    endtask : do_reset

    // read one register and compare data and valid
    task automatic read_check(input reg_byte_t a, input reg_byte_t exp);
        host_u.read_reg(a, rd_val, rd_ok);
        check(rd_val, exp);
        check({7'h00, rd_ok}, 8'h01);
    endtask : read_check

    // hang guard, far above the roughly 60 cycles the tests take
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1, 7'h2A);
        check({own, chain}, 8'h80);
        read_check(8'h1B, 8'h80);
        $display("test spi_reset done");

        // every pattern lands on the pins and reads back whole
        foreach (vals[i]) begin
            host_u.write_reg(8'h1B, vals[i]);
            check({own, chain}, vals[i]);
            read_check(8'h1B, vals[i]);
        end
        $display("test own_address done");

        host_u.write_reg(8'h1B, 8'h55);
        read_check(8'h1C, ID_EXP);
        #100;
        check({7'h00, rvalid}, 8'h00);
        host_u.write_reg(8'h1C, ~ID_EXP);
        host_u.write_reg(8'h1C, 8'h00);
        read_check(8'h1C, ID_EXP);
        check({own, chain}, 8'h55);
        $display("test id_register done");

        // nothing is taken with the clock enable low
        clk_en = 1'b0;
        host_u.write_reg(8'h1B, 8'h00);
        clk_en = 1'b1;
        check({own, chain}, 8'h55);
        read_check(8'h1D, 8'h00);
        $display("test enable_unmapped done");

        host_u.write_reg(8'h1B, 8'h01);
        do_reset(1'b0, 7'h33);
        check({own, chain}, 8'h66);
        read_check(8'h1C, ID_EXP);
        host_u.write_reg(8'h1B, 8'hA5);
        check({own, chain}, 8'hA5);
        $display("test i2c_reset done");
        end_sim();
    end
endmodule : chip_address_and_id_regs_tb

`default_nettype wire
